// ===== rtl/fsp_ctrl.sv
// Purpose: Self-programming sequencer for on-chip program flash.
// Assumes: CPU strobes are one-cycle pulses synchronous to core_clk_i.
// Notes:   Lock-bit and fuse access are not handled here.

`timescale 1ns/1ps

// ============================================================
// Sequencer
// Behaviour
// - Two-bit size setting picks boot area of 512 to 4096 words at flash top.
// - Words 0000-EFFF are concurrent-read section, F000-FFFF the blocking section.
// - During erase or write only the top section may be fetched or read.
// - Program counter is 16 bits, top bit 15.
// - Page holds 128 words; word index is pointer bits 7 to 1.
// - Page index for erase and write is pointer bits 16 to 8.
// - Pointer bit 16 comes from the separate extension register.
// - Erase bit plus enable, then store-program, erases the pointed page.
// - Enable alone with store-program loads r1:r0 into the page buffer.
// - Write bit plus enable, then store-program, writes the page.
// - Re-enable bit plus enable as store-program restores section reads.
// - Busy flag stays set until the concurrent section is readable again.
// - Store-program counts only within four cycles of control write.
// - Enabled completion interrupt stays asserted while enable is clear.
// - EEPROM write in progress blocks all flash programming.
module fsp_ctrl #(
    parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Configuration
    input wire logic boot_size_sel_hi_i,
    input wire logic boot_size_sel_lo_i,
    input wire logic irq_enable_i,
    // CPU control register and store-program
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic spm_exec_i,
    input wire logic [15:0] z_ptr_i,
    input wire logic pointer_extension_reg_i,
    input wire logic [7:0] r0_i,
    input wire logic [7:0] r1_i,
    // EEPROM status
    input wire logic eeprom_write_active_i,
    // Fetch/read address from the CPU
    input wire logic [15:0] fetch_addr_i,
    // Status to CPU
    output logic [7:0] self_prog_control_reg_o,
    output logic section_busy_flag_o,
    output logic irq_o,
    output logic fetch_allow_o,
    output logic fetch_in_boot_o,
    output logic cpu_halt_o,
    output logic lpm_byte_sel_o,
    output logic [15:0] boot_start_o,
    // Flash array commands
    output logic page_erase_o,
    output logic page_write_o,
    output logic [8:0] page_index_o,
    output logic buf_load_o,
    output logic [6:0] buf_word_o,
    output logic [15:0] buf_data_o
);

    // ========================================================
    // Elaboration checks
    // Refuse timer lengths that the 16-bit down counter cannot hold
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_bad_prog_cycles
        $error("PROG_CYCLES must be between 1 and 65535");
    end

    // ========================================================
    // Functions
    // Top section membership of a 16-bit word address
    function automatic logic top_section(input logic [15:0] addr);
        top_section = (addr > fsp_pkg::CONCURRENT_LAST);
    endfunction : top_section

    // ========================================================
    // State
    fsp_pkg::fsp_state_t state;
    fsp_pkg::fsp_state_t next_state;
    logic cmd_en;
    logic cmd_erase;
    logic cmd_write;
    logic cmd_reen;
    logic busy;
    logic [2:0] window_cnt;
    logic [15:0] prog_cnt;
    logic [8:0] op_page;
    logic next_cmd_en;
    logic next_cmd_erase;
    logic next_cmd_write;
    logic next_cmd_reen;
    logic next_busy;
    logic [2:0] next_window_cnt;
    logic [15:0] next_prog_cnt;
    logic [8:0] next_op_page;

    // ========================================================
    // Pointer decode
    // Pointer bit 0 is skipped, so each field sits one bit above its counter bit
    wire [fsp_pkg::PC_WIDTH-1:0] ptr_pc = {pointer_extension_reg_i, z_ptr_i[15:1]};
    wire [8:0] ptr_page = ptr_pc[fsp_pkg::COUNTER_TOP_BIT:fsp_pkg::PAGE_WORD_TOP_BIT+1];
    wire [6:0] ptr_word = ptr_pc[fsp_pkg::PAGE_WORD_TOP_BIT:0];
    wire [15:0] ptr_data = {r1_i, r0_i};

    // Control writes are refused while a command runs or EEPROM writes
    wire ctrl_accept = ctrl_wr_i && (state == fsp_pkg::FSP_IDLE) && !eeprom_write_active_i;
    wire wr_en = ctrl_wdata_i[fsp_pkg::CTRL_EN_BIT];
    wire spm_take = (state == fsp_pkg::FSP_ARMED) && spm_exec_i && !eeprom_write_active_i;
    wire do_erase = spm_take && cmd_erase;
    wire do_write = spm_take && !cmd_erase && cmd_write;
    wire do_reen = spm_take && !cmd_erase && !cmd_write && cmd_reen;
    wire do_fill = spm_take && !cmd_erase && !cmd_write && !cmd_reen;
    wire prog_done = (state == fsp_pkg::FSP_PROGRAM) && (prog_cnt == 16'h0000);
    wire [15:0] prog_load = 16'(PROG_CYCLES - 1);

    // ========================================================
    // Fetch decode
    wire [15:0] map_boot_start;
    wire map_in_boot;
    wire map_in_concurrent;

    fsp_addr_map u_addr_map (
        .boot_size_sel_hi_i(boot_size_sel_hi_i),
        .boot_size_sel_lo_i(boot_size_sel_lo_i),
        .addr_i(fetch_addr_i),
        .boot_start_o(map_boot_start),
        .in_boot_o(map_in_boot),
        .in_concurrent_o(map_in_concurrent)
    );

    // Concurrent section is unreadable whenever the busy flag stands
    wire next_fetch_allow = !(busy && map_in_concurrent);
    // Programming a top-section page leaves nothing to fetch, so halt the CPU
    wire next_halt = (state == fsp_pkg::FSP_PROGRAM) && top_section({op_page, 7'h00});

    // Readback image of the control register
    wire [7:0] next_ctrl_image = (8'(next_cmd_en) << fsp_pkg::CTRL_EN_BIT)
                               | (8'(next_cmd_erase) << fsp_pkg::CTRL_ERASE_BIT)
                               | (8'(next_cmd_write) << fsp_pkg::CTRL_WRITE_BIT)
                               | (8'(next_cmd_reen) << fsp_pkg::CTRL_REEN_BIT)
                               | (8'(next_busy) << fsp_pkg::CTRL_BUSY_BIT);

    // ========================================================
    // Next-state logic
    always_comb begin
        next_state = state;
        next_cmd_en = cmd_en;
        next_cmd_erase = cmd_erase;
        next_cmd_write = cmd_write;
        next_cmd_reen = cmd_reen;
        next_busy = busy;
        next_window_cnt = window_cnt;
        next_prog_cnt = prog_cnt;
        next_op_page = op_page;
        case (state)
            fsp_pkg::FSP_IDLE: begin
                if (ctrl_accept && wr_en) begin
                    // Arm the timed window with the written command bits
                    next_state = fsp_pkg::FSP_ARMED;
                    next_cmd_en = 1'b1;
                    next_cmd_erase = ctrl_wdata_i[fsp_pkg::CTRL_ERASE_BIT];
                    next_cmd_write = ctrl_wdata_i[fsp_pkg::CTRL_WRITE_BIT];
                    next_cmd_reen = ctrl_wdata_i[fsp_pkg::CTRL_REEN_BIT];
                    next_window_cnt = fsp_pkg::WINDOW_CYCLES - 3'h1;
                end else if (ctrl_accept) begin
                    // A write without enable starts nothing
                    next_cmd_erase = 1'b0;
                    next_cmd_write = 1'b0;
                    next_cmd_reen = 1'b0;
                end
            end
            fsp_pkg::FSP_ARMED: begin
                if (do_erase || do_write) begin
                    next_state = fsp_pkg::FSP_PROGRAM;
                    next_busy = 1'b1;
                    next_prog_cnt = prog_load;
                    next_op_page = ptr_page;
                end else if (spm_take) begin
                    // Fill and re-enable finish at once
                    next_state = fsp_pkg::FSP_IDLE;
                    next_cmd_en = 1'b0;
                    next_cmd_reen = 1'b0;
                    if (do_reen) begin
                        next_busy = 1'b0;
                    end
                end else if (window_cnt == 3'h0) begin
                    // Window missed: drop the command bits
                    next_state = fsp_pkg::FSP_IDLE;
                    next_cmd_en = 1'b0;
                    next_cmd_erase = 1'b0;
                    next_cmd_write = 1'b0;
                    next_cmd_reen = 1'b0;
                end else begin
                    next_window_cnt = window_cnt - 3'h1;
                end
            end
            fsp_pkg::FSP_PROGRAM: begin
                if (prog_done) begin
                    // Busy flag stays until software re-enables reads
                    next_state = fsp_pkg::FSP_IDLE;
                    next_cmd_en = 1'b0;
                    next_cmd_erase = 1'b0;
                    next_cmd_write = 1'b0;
                end else begin
                    next_prog_cnt = prog_cnt - 16'h0001;
                end
            end
            default: begin
                next_state = fsp_pkg::FSP_IDLE;
                next_cmd_en = 1'b0;
            end
        endcase
    end

    // ========================================================
    // Sequencer registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= fsp_pkg::FSP_IDLE;
            cmd_en <= 1'b0;
            cmd_erase <= 1'b0;
            cmd_write <= 1'b0;
            cmd_reen <= 1'b0;
            busy <= 1'b0;
            window_cnt <= 3'h0;
            prog_cnt <= 16'h0000;
            op_page <= 9'h000;
        end else begin
            state <= next_state;
            cmd_en <= next_cmd_en;
            cmd_erase <= next_cmd_erase;
            cmd_write <= next_cmd_write;
            cmd_reen <= next_cmd_reen;
            busy <= next_busy;
            window_cnt <= next_window_cnt;
            prog_cnt <= next_prog_cnt;
            op_page <= next_op_page;
        end
    end

    // ========================================================
    // Status outputs
    // Interrupt level follows enable low, so it keeps asking until serviced
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            self_prog_control_reg_o <= fsp_pkg::CTRL_RESET;
            section_busy_flag_o <= 1'b0;
            irq_o <= 1'b0;
            fetch_allow_o <= 1'b1;
            fetch_in_boot_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            lpm_byte_sel_o <= 1'b0;
            boot_start_o <= fsp_pkg::BOOT_START_4096;
        end else begin
            self_prog_control_reg_o <= next_ctrl_image;
            section_busy_flag_o <= next_busy;
            irq_o <= irq_enable_i && !next_cmd_en;
            fetch_allow_o <= next_fetch_allow;
            fetch_in_boot_o <= map_in_boot;
            cpu_halt_o <= next_halt;
            lpm_byte_sel_o <= z_ptr_i[0];
            boot_start_o <= map_boot_start;
        end
    end

    // ========================================================
    // Flash array commands
    // One-cycle pulses; page and buffer fields hold until the next command
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            page_erase_o <= 1'b0;
            page_write_o <= 1'b0;
            page_index_o <= 9'h000;
            buf_load_o <= 1'b0;
            buf_word_o <= 7'h00;
            buf_data_o <= 16'h0000;
        end else begin
            page_erase_o <= do_erase;
            page_write_o <= do_write;
            buf_load_o <= do_fill;
            if (do_erase || do_write) begin
                page_index_o <= ptr_page;
            end
            if (do_fill) begin
                buf_word_o <= ptr_word;
                buf_data_o <= ptr_data;
            end
        end
    end

endmodule : fsp_ctrl

// ===== rtl/fsp_pkg.sv
// Purpose: Shared constants for the flash self-programming controller.
// Assumes: 10 MHz core clock, word-addressed 64K-word program flash.
// Notes:   Control register bit positions and timing counts live here only.

// ============================================================
// Package
package fsp_pkg;

    // Control register field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_WRITE_BIT = 2;
    localparam int CTRL_REEN_BIT = 4;
    localparam int CTRL_BUSY_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Timed sequence: store-program must follow within this many cycles
    localparam logic [2:0] WINDOW_CYCLES = 3'h4;

    // Address geometry
    localparam int PC_WIDTH = 16;
    localparam int COUNTER_TOP_BIT = 15;
    localparam int PAGE_WORD_TOP_BIT = 6;
    localparam int POINTER_PAGE_WORD_TOP_BIT = 7;
    localparam int PAGE_WORDS = 128;
    localparam int PAGE_IDX_WIDTH = 9;

    // Boot area starts, selected by the two-bit size setting
    localparam logic [15:0] BOOT_START_512 = 16'hfe00;
    localparam logic [15:0] BOOT_START_1024 = 16'hfc00;
    localparam logic [15:0] BOOT_START_2048 = 16'hf800;
    localparam logic [15:0] BOOT_START_4096 = 16'hf000;

    // Section split: concurrent-read section ends here
    localparam logic [15:0] CONCURRENT_LAST = 16'hefff;

    // Flash programming time, least value, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 3700000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Controller states
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_PROGRAM
    } fsp_state_t;

endpackage : fsp_pkg

// ===== rtl/fsp_addr_map.sv
// Purpose: Decodes a word address into boot-area and section membership.
// Assumes: Boot size setting is static during operation.
// Notes:   Purely combinational; the caller registers the results.

`timescale 1ns/1ps

// ============================================================
// Address map
module fsp_addr_map (
    // Configuration
    input wire logic boot_size_sel_hi_i,
    input wire logic boot_size_sel_lo_i,
    // Address under test
    input wire logic [15:0] addr_i,
    // Decoded results
    output logic [15:0] boot_start_o,
    output logic in_boot_o,
    output logic in_concurrent_o
);

    wire [1:0] size_sel = {boot_size_sel_hi_i, boot_size_sel_lo_i};

    // Boot area start from size setting
    assign boot_start_o = (size_sel == 2'h3) ? fsp_pkg::BOOT_START_512 :
                          (size_sel == 2'h2) ? fsp_pkg::BOOT_START_1024 :
                          (size_sel == 2'h1) ? fsp_pkg::BOOT_START_2048 :
                                               fsp_pkg::BOOT_START_4096;

    // Membership checks
    assign in_boot_o = (addr_i >= boot_start_o);
    assign in_concurrent_o = (addr_i <= fsp_pkg::CONCURRENT_LAST);

endmodule : fsp_addr_map

// ===== test/fsp_checker.sv
// Purpose: Concurrent checks on the self-programming sequencer ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Watches only the sequencer's input and output ports; bound from the testbench.

`timescale 1ns/1ps

// ============================================================
// Checker
module fsp_checker #(
    parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Inputs seen by the sequencer
    input wire logic boot_size_sel_hi_i,
    input wire logic boot_size_sel_lo_i,
    input wire logic irq_enable_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic spm_exec_i,
    input wire logic [15:0] z_ptr_i,
    input wire logic pointer_extension_reg_i,
    input wire logic [7:0] r0_i,
    input wire logic [7:0] r1_i,
    input wire logic eeprom_write_active_i,
    input wire logic [15:0] fetch_addr_i,
    // Outputs of the sequencer
    input wire logic [7:0] self_prog_control_reg_o,
    input wire logic section_busy_flag_o,
    input wire logic irq_o,
    input wire logic fetch_allow_o,
    input wire logic lpm_byte_sel_o,
    input wire logic [15:0] boot_start_o,
    input wire logic page_erase_o,
    input wire logic page_write_o,
    input wire logic [8:0] page_index_o,
    input wire logic buf_load_o,
    input wire logic [6:0] buf_word_o,
    input wire logic [15:0] buf_data_o
);
    // Expected boot start decoded from the inputs; idle condition from enable readback and EEPROM status
    wire logic [1:0] sel = {boot_size_sel_hi_i, boot_size_sel_lo_i};
    wire logic [15:0] exp_boot = sel == 2'h3 ? 16'hfe00 : sel == 2'h2 ? 16'hfc00 :
        sel == 2'h1 ? 16'hf800 : 16'hf000;
    wire logic idle = !self_prog_control_reg_o[0] && !eeprom_write_active_i;
    // Lower reads stay blocked for as long as the busy flag stands
    wire logic prog = section_busy_flag_o;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    // Timed pair: control write while idle, then the store-program strobe
    sequence arm_s(logic [7:0] w);
        ctrl_wr_i && ctrl_wdata_i == w && idle;
    endsequence
    sequence spm_s;
        spm_exec_i && !eeprom_write_active_i;
    endsequence

    a_erase_page: assert property (
        arm_s(8'h03) ##1 spm_s |=> page_erase_o &&
        page_index_o == {$past(pointer_extension_reg_i), $past(z_ptr_i[15:8])})
        else $error("page erase pulse or page index wrong");
    a_fill_word: assert property (
        arm_s(8'h01) ##1 spm_s |=> buf_load_o && buf_word_o == $past(z_ptr_i[7:1]) &&
        buf_data_o == {$past(r1_i), $past(r0_i)})
        else $error("buffer load wrong");
    a_late_spm: assert property (
        arm_s(8'h03) ##1 (!spm_exec_i && !ctrl_wr_i)[*4] ##1 spm_exec_i |=> !page_erase_o)
        else $error("late store-program was taken");
    a_pulse_cause: assert property (
        (page_erase_o || page_write_o || buf_load_o) |-> $past(spm_exec_i))
        else $error("command pulse without store-program");
    a_busy_clear: assert property (
        $fell(section_busy_flag_o) |-> $past(spm_exec_i) || $past(spm_exec_i, 2))
        else $error("busy flag dropped without a command");
    a_eeprom_block: assert property (
        eeprom_write_active_i && ctrl_wr_i && !self_prog_control_reg_o[0]
        |=> !self_prog_control_reg_o[0])
        else $error("control write accepted during eeprom write");
    a_fetch_block: assert property (
        prog && fetch_addr_i <= 16'hefff |=> !fetch_allow_o)
        else $error("lower section read during programming");
    a_top_allowed: assert property (
        fetch_addr_i >= 16'hf000 |=> fetch_allow_o)
        else $error("top section read blocked");
    a_irq_level: assert property (
        1'b1 |-> irq_o == ($past(irq_enable_i) && !self_prog_control_reg_o[0]))
        else $error("completion interrupt level wrong");
    a_byte_sel: assert property (
        1'b1 |=> lpm_byte_sel_o == $past(z_ptr_i[0]))
        else $error("byte select wrong");
    a_boot_map: assert property (
        1'b1 |=> boot_start_o == $past(exp_boot))
        else $error("boot start wrong");
endmodule : fsp_checker

// ===== test/testbench.sv
// Purpose: Self-checking bench for the self-programming sequencer.
// Assumes: Inputs change on the falling edge; programming shortened to 20 cycles.
// Notes:   Command results are noted in a queue and matched when pulses appear.

`timescale 1ns/1ps

// ============================================================
// Testbench
module testbench;
    logic core_clk_i, srst_i, hi, lo, irq_en, wr, spm, ext, eew;
    logic [7:0] wd, r0, r1, ctrl;
    logic [15:0] z, fa, boot;
    logic busy, irq, allow, in_boot, halt, bsel, er, pw, ld;
    logic [8:0] pidx;
    logic [6:0] bw;
    logic [15:0] bd;
    logic [26:0] notes[$];
    logic [26:0] seen;
    logic [31:0] seed = 32'h6829;
    logic [31:0] tmp;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    fsp_ctrl #(.PROG_CYCLES(20)) dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .boot_size_sel_hi_i(hi), .boot_size_sel_lo_i(lo), .irq_enable_i(irq_en),
        .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .spm_exec_i(spm), .z_ptr_i(z),
        .pointer_extension_reg_i(ext), .r0_i(r0), .r1_i(r1), .eeprom_write_active_i(eew),
        .fetch_addr_i(fa), .self_prog_control_reg_o(ctrl), .section_busy_flag_o(busy),
        .irq_o(irq), .fetch_allow_o(allow), .fetch_in_boot_o(in_boot), .cpu_halt_o(halt),
        .lpm_byte_sel_o(bsel), .boot_start_o(boot), .page_erase_o(er), .page_write_o(pw),
        .page_index_o(pidx), .buf_load_o(ld), .buf_word_o(bw), .buf_data_o(bd));

    // Clock, 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    // Poll enable low under a bound, as software does before each command
    task automatic cmd(input logic [7:0] w, input int gap);
        int i;
        i = 0;
        cyc(1);
        while (ctrl[0] !== 1'b0 && i < 200) begin
            cyc(1);
            i++;
        end
        check("enable idle", ctrl[0], 1'b0);
        wr = 1'b1; // nothing may intervene in the timed pair
        wd = w;
        cyc(1);
        wr = 1'b0;
        cyc(gap - 1);
        spm = 1'b1;
        cyc(1);
        spm = 1'b0;
    endtask : cmd

    // Watcher: every command pulse must match the oldest note
    always @(negedge core_clk_i) begin
        if (srst_i === 1'b0 && (ld === 1'b1 || er === 1'b1 || pw === 1'b1)) begin
            seen = ld ? {2'h1, bd, 2'h0, bw} : {pw ? 2'h3 : 2'h2, 16'h0000, pidx};
            check("command result", seen, notes.size() ? notes.pop_front() : 27'h0);
        end
    end

    // Hang guard, well above the expected run of about 150 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        srst_i = 1'b1;
        {hi, lo, irq_en, wr, spm, ext, eew, wd, r0, r1, z, fa} = '0;
        cyc(19);
        check("reset readback", {ctrl, allow, boot}, {8'h00, 1'b1, 16'hf000});
        cyc(1);
        srst_i = 1'b0;
        // Boot size settings and boot membership of a fetch address
        for (int s = 0; s < 4; s++) begin
            {hi, lo} = s[1:0];
            tmp = s == 3 ? 32'hfe00 : s == 2 ? 32'hfc00 : s == 1 ? 32'hf800 : 32'hf000;
            fa = tmp[15:0];
            cyc(3);
            check("boot start", boot, tmp);
            check("in boot", in_boot, 1'b1);
            fa = tmp[15:0] - 16'h0001;
            cyc(2);
            check("below boot", in_boot, 1'b0);
        end
        z = 16'h0001;
        cyc(2);
        check("byte select", bsel, 1'b1);
        // Erase a random lower page; lower reads blocked, top reads kept
        irq_en = 1'b1;
        tmp = xs();
        z = {tmp[15:8], 8'h00};
        notes.push_back({2'h2, 16'h0000, 1'b0, tmp[15:8]});
        cmd(8'h03, 1);
        fa = 16'hefff;
        cyc(2);
        check("erase status", {ctrl, busy, allow, halt, irq}, {8'h43, 4'h8});
        fa = 16'hf000;
        cyc(2);
        check("top fetch", allow, 1'b1);
        cyc(25);
        check("erase done", {ctrl, busy, irq}, {8'h40, 2'h3});
        cmd(8'h11, 1);
        cyc(3);
        check("reenabled", {busy, ctrl}, 9'h000);
        // Fill four words, window gaps 1 to 4 cycles
        tmp = xs();
        ext = tmp[16];
        for (int i = 0; i < 4; i++) begin
            z = {tmp[15:4], 4'h0} + 16'(2 * i);
            {r1, r0} = 16'(xs());
            notes.push_back({2'h1, r1, r0, 2'h0, z[7:1]});
            cmd(8'h01, i + 1);
        end
        // Page write in the top section halts the core
        ext = 1'b1;
        z = 16'he000;
        notes.push_back({2'h3, 16'h0000, 9'h1e0});
        cmd(8'h05, 1);
        cyc(2);
        check("write status", {ctrl, halt}, {8'h45, 1'b1});
        cmd(8'h11, 1);
        cyc(3);
        check("write done", {busy, halt}, 2'h0);
        // Store-program one cycle too late is dropped
        cmd(8'h03, 5);
        cyc(2);
        check("late spm", ctrl, 8'h00);
        // Control write during an eeprom write is refused
        eew = 1'b1;
        cmd(8'h01, 1);
        cyc(1);
        check("eeprom block", ctrl, 8'h00);
        eew = 1'b0;
        cyc(4);
        check("notes left", notes.size(), 0);
        close_out();
    end
endmodule : testbench

bind fsp_ctrl fsp_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .boot_size_sel_hi_i(boot_size_sel_hi_i),
    .boot_size_sel_lo_i(boot_size_sel_lo_i), .irq_enable_i(irq_enable_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .spm_exec_i(spm_exec_i),
    .z_ptr_i(z_ptr_i), .pointer_extension_reg_i(pointer_extension_reg_i), .r0_i(r0_i),
    .r1_i(r1_i), .eeprom_write_active_i(eeprom_write_active_i), .fetch_addr_i(fetch_addr_i),
    .self_prog_control_reg_o(self_prog_control_reg_o), .irq_o(irq_o),
    .section_busy_flag_o(section_busy_flag_o), .fetch_allow_o(fetch_allow_o),
    .lpm_byte_sel_o(lpm_byte_sel_o), .boot_start_o(boot_start_o), .page_erase_o(page_erase_o),
    .page_write_o(page_write_o), .page_index_o(page_index_o), .buf_load_o(buf_load_o),
    .buf_word_o(buf_word_o), .buf_data_o(buf_data_o));
